//--- src/ufc_flow.sv
/*
 * Flow control of one uart channel: auto cts gating, in-band pause and
 * resume recognition on the receive stream and flow character sending.
 * Assumes a transmit shifter, a receiver and fifos outside: bytes come
 * in with error flags, the shifter reports stop bit midpoint and done.
 */
`timescale 1ns/1ps
`include "ufc_params.svh"
module ufc_flow #(
   parameter int FIFO_DEPTH = 64
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [3:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [7:0]                reg_rdata,
   input  wire logic                 cts_n,
   input  wire logic [1:0]           word_len,
   input  wire logic                 txf_valid,
   input  wire logic [7:0]           txf_data,
   output logic                      txf_pop,
   output logic                      tx_start,
   output logic [7:0]                tx_data,
   input  wire logic                 tx_busy,
   input  wire logic                 tx_stop_mid,
   input  wire logic                 rx_valid,
   input  wire logic [7:0]           rx_data,
   input  wire logic                 rx_err,
   output logic                      rxf_push,
   output logic [7:0]                rxf_data,
   input  wire logic [6:0]           rx_level,
   output logic                      flow_irq
);
   import ufc_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] enhanced_feature_reg;
   logic [7:0] modem_control_reg;
   logic [7:0] interrupt_enable_reg;
   logic [7:0] threshold_control_reg;
   logic [7:0] resume_char_first;
   logic [7:0] resume_char_second;
   logic [7:0] pause_char_first;
   logic [7:0] pause_char_second;
   logic       pause_flag;
   logic       special_flag;
   logic       halted;
   logic       pause_sent;
   logic       rd_ident;

   assign rd_ident = reg_rd && (reg_addr == `UFC_ADDR_IIDENT);

   // control registers, cleared by reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enhanced_feature_reg  <= `UFC_RST_REG;
         modem_control_reg     <= `UFC_RST_REG;
         interrupt_enable_reg  <= `UFC_RST_REG;
         threshold_control_reg <= `UFC_RST_REG;
      end else if (reg_wr) begin
         case (reg_addr)
            `UFC_ADDR_FEATURE: enhanced_feature_reg  <= reg_wdata;
            `UFC_ADDR_MODEM:   modem_control_reg     <= reg_wdata;
            `UFC_ADDR_IENABLE: interrupt_enable_reg  <= reg_wdata;
            `UFC_ADDR_THRESH:  threshold_control_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // flow characters keep their value over reset, so no reset branch
   always_ff @(posedge core_clk) begin
      if (reg_wr) begin
         case (reg_addr)
            `UFC_ADDR_RES1: resume_char_first  <= reg_wdata;
            `UFC_ADDR_RES2: resume_char_second <= reg_wdata;
            `UFC_ADDR_PAU1: pause_char_first   <= reg_wdata;
            `UFC_ADDR_PAU2: pause_char_second  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `UFC_ADDR_FEATURE: reg_rdata <= enhanced_feature_reg;
            `UFC_ADDR_MODEM:   reg_rdata <= modem_control_reg;
            `UFC_ADDR_IENABLE: reg_rdata <= interrupt_enable_reg;
            `UFC_ADDR_IIDENT:  reg_rdata <= {3'h0, pause_flag | special_flag, 4'h1};
            `UFC_ADDR_THRESH:  reg_rdata <= threshold_control_reg;
            `UFC_ADDR_RES1:    reg_rdata <= resume_char_first;
            `UFC_ADDR_RES2:    reg_rdata <= resume_char_second;
            `UFC_ADDR_PAU1:    reg_rdata <= pause_char_first;
            `UFC_ADDR_PAU2:    reg_rdata <= pause_char_second;
            `UFC_ADDR_STATUS:  reg_rdata <= {6'h00, pause_sent, halted};
            default:           reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // receive side recognition
   // ------------------------------------------------------------
   logic [1:0] rx_sel;
   logic       rx_on;
   logic       rx_seq;
   logic       use1;
   logic       use2;
   logic       pend_pause;    // first pause char seen, waiting for second
   logic       pend_resume;   // first resume char seen, waiting for second
   logic       hit_pause;
   logic       hit_resume;
   logic       hit_any;
   logic       hit_special;
   logic       eat;           // byte consumed as flow character
   logic       flush_first;   // unpaired first char must be stored
   logic [7:0] flush_char;

   assign rx_sel = enhanced_feature_reg[1:0];
   assign rx_on  = rx_sel != 2'b00;
   assign rx_seq = rx_sel == 2'b11;
   assign use1   = rx_sel == 2'b10;
   assign use2   = rx_sel == 2'b01;

   // match decode; errored bytes never count as flow characters
   always_comb begin
      hit_pause   = 1'b0;
      hit_resume  = 1'b0;
      hit_any     = 1'b0;
      hit_special = 1'b0;
      flush_first = 1'b0;
      flush_char  = 8'h00;
      if (rx_valid && !rx_err) begin
         if (rx_on) begin
            if (use1) begin
               hit_pause  = rx_data == pause_char_first;
               hit_resume = rx_data == resume_char_first;
            end else if (use2) begin
               hit_pause  = rx_data == pause_char_second;
               hit_resume = rx_data == resume_char_second;
            end else begin
               hit_pause  = pend_pause && rx_data == pause_char_second;
               hit_resume = pend_resume && rx_data == resume_char_second;
            end
         end
         // resume-any takes a first resume char as any char; it and the second land in fifo
         hit_any = halted && modem_control_reg[`UFC_MODEM_ANY]
                   && !hit_pause;
         hit_special = enhanced_feature_reg[`UFC_FEAT_SPECIAL]
                       && rx_data == pause_char_second;
      end
      if (rx_valid && (pend_pause || pend_resume) && !hit_pause && !hit_resume) begin
         flush_first = 1'b1;
         flush_char  = pend_pause ? pause_char_first : resume_char_first;
      end
   end

   // first halves of sequential pairs are held back until the second
   logic is_first;
   assign is_first = rx_valid && !rx_err && rx_on && rx_seq && !hit_any
                     && (rx_data == pause_char_first || rx_data == resume_char_first);
   assign eat = hit_pause || (hit_resume && !hit_any) || is_first;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pend_pause  <= 1'b0;
         pend_resume <= 1'b0;
      end else if (rx_valid) begin
         pend_pause  <= is_first && rx_data == pause_char_first;
         pend_resume <= is_first && rx_data == resume_char_first;
      end
   end

   // ------------------------------------------------------------
   // receive fifo write path; flushed first char goes before this byte
   // ------------------------------------------------------------
   logic       hold_valid;
   logic [7:0] hold_data;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxf_push   <= 1'b0;
         rxf_data   <= 8'h00;
         hold_valid <= 1'b0;
         hold_data  <= 8'h00;
      end else begin
         rxf_push <= 1'b0;
         if (flush_first) begin
            rxf_push <= 1'b1;
            rxf_data <= flush_char;
         end else if (hold_valid) begin
            rxf_push <= 1'b1;
            rxf_data <= hold_data;
         end else if (rx_valid && !eat) begin
            rxf_push <= 1'b1;
            rxf_data <= rx_data;
         end
         // byte behind a flush waits one cycle, bytes are far apart
         hold_valid <= flush_first && !eat;
         hold_data  <= rx_data;
      end
   end

   // halt state and interrupt flags; set beats clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         halted       <= 1'b0;
         pause_flag   <= 1'b0;
         special_flag <= 1'b0;
      end else begin
         if (hit_pause)
            halted <= 1'b1;
         else if (hit_resume || hit_any || !rx_on)
            halted <= 1'b0;
         if (hit_pause && interrupt_enable_reg[`UFC_IEN_FLOW])
            pause_flag <= 1'b1;
         else if (hit_resume || hit_any)
            pause_flag <= 1'b0;
         if (hit_special)
            special_flag <= 1'b1;
         else if (rd_ident)
            special_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         flow_irq <= 1'b0;
      else
         flow_irq <= interrupt_enable_reg[`UFC_IEN_FLOW] && (pause_flag || special_flag);
   end

   // ------------------------------------------------------------
   // flow character request from receive fifo level
   // ------------------------------------------------------------
   logic [3:0]   sent_sel;      // flow selection (feature bits 3:0) used for last pause
   logic [3:0]   cur_sel;
   logic         above;
   logic         at_resume;
   logic         want_pause;
   logic         want_resume;
   logic [6:0]   halt_lvl;
   logic [6:0]   resume_lvl;

   assign cur_sel    = enhanced_feature_reg[3:0];
   // nibble counts in units of four entries
   assign halt_lvl   = {1'b0, threshold_control_reg[3:0], 2'b00};
   assign resume_lvl = {1'b0, threshold_control_reg[7:4], 2'b00};
   assign above      = rx_level > halt_lvl;
   assign at_resume  = rx_level <= resume_lvl;
   assign want_pause  = !pause_sent && above && cur_sel[3:2] != 2'b00;
   assign want_resume = pause_sent && (at_resume || cur_sel != sent_sel);

   // ------------------------------------------------------------
   // transmit sequencing
   // ------------------------------------------------------------
   ufc_tx_e    tx_state;
   ufc_send_e  send_kind;
   logic [1:0] send_pair;       // transmit pairs selected for this send
   logic       send_second;     // second char pending: after the first of a 11 sequence, or from the start for 01
   logic       cts_ok;
   logic       cts_block;
   logic [7:0] mask;
   logic [7:0] next_char;

   assign cts_ok = !enhanced_feature_reg[`UFC_FEAT_AUTO_CTS] || !cts_n;

   // short words send only the low bits of the character
   always_comb begin
      case (word_len)
         2'b00:   mask = 8'h1f;
         2'b01:   mask = 8'h3f;
         2'b10:   mask = 8'h7f;
         default: mask = 8'hff;
      endcase
   end

   always_comb begin
      case ({send_kind == UFC_SEND_PAUSE, send_pair[1] && !send_second})
         2'b11:   next_char = pause_char_first;
         2'b10:   next_char = pause_char_second;
         2'b01:   next_char = resume_char_first;
         default: next_char = resume_char_second;
      endcase
   end

   // cts sampled up to stop bit midpoint decides whether next byte may go
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         cts_block <= 1'b0;
      else if (tx_stop_mid || !tx_busy)
         cts_block <= !cts_ok;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_state    <= UFC_TX_IDLE;
         send_kind   <= UFC_SEND_NONE;
         send_pair   <= 2'b00;
         send_second <= 1'b0;
         pause_sent  <= 1'b0;
         sent_sel    <= 4'h0;
         tx_start    <= 1'b0;
         tx_data     <= 8'h00;
         txf_pop     <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         txf_pop  <= 1'b0;
         case (tx_state)
            UFC_TX_IDLE: begin
               if (!tx_busy && !cts_block && cts_ok) begin
                  if (send_kind != UFC_SEND_NONE) begin
                     tx_state <= UFC_TX_LOAD;
                  end else if (want_resume) begin
                     send_kind   <= UFC_SEND_RESUME;
                     send_pair   <= sent_sel[3:2] == 2'b00 ? 2'b10 : sent_sel[3:2];
                     send_second <= sent_sel[3:2] == 2'b01;
                     tx_state    <= UFC_TX_LOAD;
                  end else if (want_pause) begin
                     send_kind   <= UFC_SEND_PAUSE;
                     send_pair   <= cur_sel[3:2];
                     send_second <= cur_sel[3:2] == 2'b01;
                     sent_sel    <= cur_sel;
                     tx_state    <= UFC_TX_LOAD;
                  end else if (txf_valid && !halted) begin
                     tx_start <= 1'b1;
                     tx_data  <= txf_data;
                     txf_pop  <= 1'b1;
                     tx_state <= UFC_TX_SHIFT;
                  end
               end
            end
            UFC_TX_LOAD: begin
               tx_start <= 1'b1;
               tx_data  <= next_char & mask;
               tx_state <= UFC_TX_SHIFT;
               if (send_pair == 2'b11 && !send_second) begin
                  send_second <= 1'b1;
               end else begin
                  pause_sent <= send_kind == UFC_SEND_PAUSE;
                  send_kind  <= UFC_SEND_NONE;
               end
            end
            UFC_TX_SHIFT: begin
               if (!tx_start && !tx_busy)
                  tx_state <= UFC_TX_IDLE;
            end
            default: tx_state <= UFC_TX_IDLE;
         endcase
      end
   end
endmodule : ufc_flow

//--- src/ufc_params.svh
/*
 * Constants of the uart flow control block: register offsets, field
 * positions, reset values. Assumes inclusion by bare name from src/.
 */
// What this block does
// - auto cts: start byte only while cts low
// - cts late: finish byte, hold next
// - cts back low: resume queued data
// - no auto cts: send regardless of cts
// - feature bits 3:0 select software flow
// - bits 3:2 select transmitted flow characters
// - bits 1:0 select compared flow characters
// - pause received: halt tx, flag interrupt
// - resume received: clear flag, continue tx
// - resume-any bit: any error-free char but a pause resumes
// - first resume may count as any char
// - special char flags, no halt, stored
// - errored flow char is ordinary data
// - unpaired first char goes into fifo
// - fill above halt level sends pause
// - fill down to resume level sends resume
// - flow disabled after pause sends resume
// - selection change: old resume, new pause
// - flow chars framed like data bytes
// - feature bit 7 enables auto cts
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UFC_ADDR_FEATURE   4'h0
`define UFC_ADDR_MODEM     4'h1
`define UFC_ADDR_IENABLE   4'h2
`define UFC_ADDR_IIDENT    4'h3
`define UFC_ADDR_THRESH    4'h4
`define UFC_ADDR_RES1      4'h5
`define UFC_ADDR_RES2      4'h6
`define UFC_ADDR_PAU1      4'h7
`define UFC_ADDR_PAU2      4'h8
`define UFC_ADDR_STATUS    4'h9
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFC_FEAT_AUTO_CTS  7
`define UFC_FEAT_AUTO_RTS  6
`define UFC_FEAT_SPECIAL   5
`define UFC_MODEM_ANY      5
`define UFC_IEN_FLOW       5
`define UFC_IID_FLOW       4
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UFC_RST_REG        8'h00
`define UFC_RST_CHAR       8'h00
`endif

//--- src/ufc_pkg.sv
/*
 * Types of the uart flow control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ufc_pkg;
   // transmit side states
   typedef enum logic [2:0] {
      UFC_TX_IDLE  = 3'b000,
      UFC_TX_LOAD  = 3'b001,
      UFC_TX_SHIFT = 3'b010
   } ufc_tx_e;
   // what the next transmitted flow character is
   typedef enum logic [1:0] {
      UFC_SEND_NONE   = 2'b00,
      UFC_SEND_PAUSE  = 2'b01,
      UFC_SEND_RESUME = 2'b10
   } ufc_send_e;
endpackage : ufc_pkg

//--- tb/ufc_flow_assertions.sv
/*
 * Port-level checker of ufc_flow, bound to every instance.
 * Assumes the register map of ufc_params.svh and the hand-over timing.
 */
`timescale 1ns/1ps
`include "ufc_params.svh"
module ufc_flow_assertions (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cts_n,
   input wire logic [1:0] word_len,
   input wire logic       txf_valid,
   input wire logic [7:0] txf_data,
   input wire logic       txf_pop,
   input wire logic       tx_start,
   input wire logic [7:0] tx_data,
   input wire logic       tx_busy,
   input wire logic       tx_stop_mid,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_err,
   input wire logic       rxf_push,
   input wire logic [7:0] rxf_data,
   input wire logic [6:0] rx_level,
   input wire logic       flow_irq
);
   logic [7:0] feat;
   logic [7:0] ien;
   // -----------------------------------------------------------
   // shadow registers
   // -----------------------------------------------------------
   // copies of feature and enable, rebuilt from bus writes only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         feat <= 8'h00;
         ien  <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `UFC_ADDR_FEATURE) feat <= reg_wdata;
         if (reg_addr == `UFC_ADDR_IENABLE) ien <= reg_wdata;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // past feature value: the start decision is one edge older than the pop
   a_cts_gates_pop: assert property
      (txf_pop && $past(feat[7]) |-> !$past(cts_n)) else $error("pop with cts high");
   a_start_one_cycle: assert property
      (tx_start |=> !tx_start) else $error("start longer than a cycle");
   a_start_when_idle: assert property
      (tx_start |-> !tx_busy) else $error("start while shifter busy");
   a_pop_with_start: assert property
      (txf_pop |-> tx_start) else $error("pop without start");
   a_flow_char_masked: assert property
      (tx_start && !txf_pop && word_len == 2'b00 |-> tx_data[7:5] == 3'b000)
      else $error("flow char not masked to five bits");
   a_tx_data_holds: assert property
      (!tx_start |-> $stable(tx_data)) else $error("tx data moved without start");
   a_err_char_stored: assert property
      (rx_valid && rx_err |=> rxf_push) else $error("errored byte not pushed");
   a_push_follows_rx: assert property
      (rxf_push |-> $past(rx_valid) || $past(rx_valid, 2)) else $error("push without byte");
   a_irq_needs_enable: assert property
      (!ien[5] && !$past(ien[5]) |-> !flow_irq) else $error("irq while disabled");
   a_ident_read_form: assert property
      ($past(reg_rd) && $past(reg_addr) == `UFC_ADDR_IIDENT
       |-> reg_rdata[3:0] == 4'h1 && reg_rdata[7:5] == 3'b000) else $error("bad ident");
   a_unmapped_zero: assert property
      ($past(reg_rd) && $past(reg_addr) > `UFC_ADDR_STATUS |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : ufc_flow_assertions

bind ufc_flow ufc_flow_assertions u_chk (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n),
   .word_len(word_len), .txf_valid(txf_valid), .txf_data(txf_data), .txf_pop(txf_pop),
   .tx_start(tx_start), .tx_data(tx_data), .tx_busy(tx_busy), .tx_stop_mid(tx_stop_mid),
   .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rxf_push(rxf_push),
   .rxf_data(rxf_data), .rx_level(rx_level), .flow_irq(flow_irq));

//--- tb/ufc_line_model.sv
/*
 * Behavioural transmit shifter and line towards the remote uart.
 * Assumes tx_start is a one-cycle pulse with tx_data beside it.
 */
`timescale 1ns/1ps
module ufc_line_model #(
   parameter int BYTE_CYC = 12
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_data,
   output logic            tx_busy,
   output logic            tx_stop_mid,
   output logic [7:0]      last_byte,
   output logic [7:0]      n_sent
);
   int cnt;
   // one byte per start; short frame keeps the run brief
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt         <= 0;
         tx_busy     <= 1'b0;
         tx_stop_mid <= 1'b0;
         last_byte   <= 8'h00;
         n_sent      <= 8'h00;
      end else begin
         tx_stop_mid <= 1'b0;
         if (tx_start) begin
            cnt       <= BYTE_CYC;
            tx_busy   <= 1'b1;
            last_byte <= tx_data;
            n_sent    <= n_sent + 8'h01;
         end else if (cnt != 0) begin
            cnt         <= cnt - 1;
            tx_stop_mid <= (cnt == 3);
            tx_busy     <= (cnt != 1);
         end
      end
   end
endmodule : ufc_line_model

//--- tb/tb_top.sv
/*
 * Self-checking bench of ufc_flow: bus tasks, receive byte task,
 * transmit fifo stand-in and a shifter model on the far side.
 * Assumes the register map and reset behaviour of the hand-over.
 */
`timescale 1ns/1ps
`include "ufc_params.svh"
module tb_top;
   logic       core_clk  = 1'b0;
   logic       rst       = 1'b1;
   logic [3:0] reg_addr  = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic       cts_n     = 1'b0;
   logic [1:0] word_len  = 2'b11;
   logic       txf_valid = 1'b0;
   logic [7:0] txf_data  = 8'h00;
   logic       rx_valid  = 1'b0;
   logic [7:0] rx_data   = 8'h00;
   logic       rx_err    = 1'b0;
   logic [6:0] rx_level  = 7'h00;
   logic [7:0] n_push    = 8'h00;
   logic [7:0] last_push = 8'h00;
   logic [7:0] reg_rdata, tx_data, rxf_data, last_byte, n_sent;
   logic       txf_pop, tx_start, tx_busy, tx_stop_mid, rxf_push, flow_irq;
   int         failures  = 0;
   int         n_tests   = 0;

   always #2 core_clk = ~core_clk;

   ufc_flow dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n),
      .word_len(word_len), .txf_valid(txf_valid), .txf_data(txf_data),
      .txf_pop(txf_pop), .tx_start(tx_start), .tx_data(tx_data), .tx_busy(tx_busy),
      .tx_stop_mid(tx_stop_mid), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_err(rx_err), .rxf_push(rxf_push), .rxf_data(rxf_data),
      .rx_level(rx_level), .flow_irq(flow_irq));
   ufc_line_model line (
      .core_clk(core_clk), .rst(rst), .tx_start(tx_start), .tx_data(tx_data),
      .tx_busy(tx_busy), .tx_stop_mid(tx_stop_mid), .last_byte(last_byte),
      .n_sent(n_sent));

   // ------------------------------------------------------------
   // fifo stand-ins
   // ------------------------------------------------------------
   // one-entry transmit fifo emptied by pop; receive pushes counted
   always @(posedge core_clk) begin
      if (rxf_push === 1'b1) begin
         n_push    <= n_push + 8'h01;
         last_push <= rxf_data;
      end
      if (txf_pop === 1'b1) txf_valid <= 1'b0;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   // spacing of four idle cycles covers a flushed first char as well
   task automatic rx(input logic [7:0] b, input logic e);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
      rx_err   <= e;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : rx
   task automatic send(input logic [7:0] b);
      @(posedge core_clk);
      txf_valid <= 1'b1;
      txf_data  <= b;
   endtask : send
   task automatic wait_sent(input logic [7:0] n);
      for (int i = 0; i < 200 && n_sent !== n; i++) @(posedge core_clk);
      #1;
      chk(n_sent, n);
   endtask : wait_sent
   // absence check: a held byte must stay unsent over several frames
   task automatic stay(input logic [7:0] n);
      repeat (40) @(posedge core_clk);
      #1;
      chk(n_sent, n);
   endtask : stay
   task automatic results();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      results();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      rd(`UFC_ADDR_FEATURE, 8'h00);
      rd(`UFC_ADDR_IIDENT, 8'h01);
      wr(4'hf, 8'haa);
      rd(4'hf, 8'h00);
      wr(`UFC_ADDR_MODEM, 8'h20);
      rd(`UFC_ADDR_MODEM, 8'h20);
      wr(`UFC_ADDR_MODEM, 8'h00);
      $display("test registers done");
      cts_n <= 1'b1;
      send(8'ha5);
      wait_sent(8'h01);
      wr(`UFC_ADDR_FEATURE, 8'h80);
      send(8'h3c);
      stay(8'h01);
      cts_n <= 1'b0;
      wait_sent(8'h02);
      cts_n <= 1'b1;
      send(8'h5a);
      stay(8'h02);
      cts_n <= 1'b0;
      wait_sent(8'h03);
      chk(last_byte, 8'h5a);
      $display("test cts done");
      wr(`UFC_ADDR_FEATURE, 8'h02);
      wr(`UFC_ADDR_IENABLE, 8'h20);
      wr(`UFC_ADDR_PAU1, 8'hf3);
      wr(`UFC_ADDR_RES1, 8'he1);
      // flow chars have no reset value, so every one is written before use
      wr(`UFC_ADDR_RES2, 8'hd2);
      rx(8'hf3, 1'b0);
      rd(`UFC_ADDR_STATUS, 8'h01);
      chk({7'h00, flow_irq}, 8'h01);
      send(8'h77);
      stay(8'h03);
      rx(8'he1, 1'b0);
      wait_sent(8'h04);
      chk({7'h00, flow_irq}, 8'h00);
      chk(n_push, 8'h00);
      rx(8'hf3, 1'b1);
      chk(last_push, 8'hf3);
      rd(`UFC_ADDR_STATUS, 8'h00);
      $display("test receive pause done");
      wr(`UFC_ADDR_FEATURE, 8'h01);
      wr(`UFC_ADDR_PAU2, 8'hc7);
      wr(`UFC_ADDR_MODEM, 8'h20);
      rx(8'hf3, 1'b0);
      chk(n_push, 8'h02);
      rx(8'hc7, 1'b0);
      rd(`UFC_ADDR_STATUS, 8'h01);
      rx(8'h41, 1'b0);
      rd(`UFC_ADDR_STATUS, 8'h00);
      chk(last_push, 8'h41);
      $display("test resume any done");
      wr(`UFC_ADDR_THRESH, 8'h12);
      wr(`UFC_ADDR_FEATURE, 8'h08);
      word_len <= 2'b00;
      rx_level <= 7'h09;
      wait_sent(8'h05);
      chk(last_byte, 8'h13);
      repeat (16) @(posedge core_clk);
      rd(`UFC_ADDR_STATUS, 8'h02);
      rx_level <= 7'h04;
      wait_sent(8'h06);
      chk(last_byte, 8'h01);
      repeat (16) @(posedge core_clk);
      rd(`UFC_ADDR_STATUS, 8'h00);
      $display("test thresholds done");
      wr(`UFC_ADDR_FEATURE, 8'h20);
      rx(8'hc7, 1'b0);
      chk(last_push, 8'hc7);
      chk({7'h00, flow_irq}, 8'h01);
      rd(`UFC_ADDR_IIDENT, 8'h11);
      rd(`UFC_ADDR_IIDENT, 8'h01);
      rd(`UFC_ADDR_STATUS, 8'h00);
      $display("test special char done");
      results();
   end
endmodule : tb_top
